// *** hdl/tbtc_top.sv ***
// Word-count and transfer-pointer data-break controller for a tape transport.
`timescale 1ns/1ps

module tbtc_top
  import tbtc_pkg::*;
(
  input  wire logic               CORE_CLK,
  input  wire logic               RSTN,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [PADDR_W-1:0] PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  output logic                    IRQ,
  output logic                    MEM_REQ,
  output logic                    MEM_WE,
  output logic      [WORD_W-1:0]  MEM_ADDR,
  output logic      [WORD_W-1:0]  MEM_WDATA,
  input  wire logic               MEM_ACK,
  input  wire logic [WORD_W-1:0]  MEM_RDATA,
  input  wire logic               TAPE_MARK_STB,
  input  wire logic [WORD_W-1:0]  TAPE_MARK_NUM,
  input  wire logic               TAPE_RWORD_STB,
  input  wire logic [WORD_W-1:0]  TAPE_RWORD,
  input  wire logic               TAPE_WREQ_STB,
  input  wire logic               TAPE_BLOCK_END,
  output logic                    TAPE_WWORD_STB,
  output logic      [WORD_W-1:0]  TAPE_WWORD,
  output logic                    TAPE_RUN,
  output logic                    TAPE_REVERSE
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [WORD_W-1:0] inc_word(input logic [WORD_W-1:0] w);
    inc_word = w + WORD_ONE;
  endfunction : inc_word

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic                active;
  logic                next_active;
  tbtc_fn_e            fn;
  tbtc_fn_e            next_fn;
  logic                continuous_mode;
  logic                next_continuous_mode;
  logic                reverse;
  logic                next_reverse;
  logic                halted;
  logic                next_halted;
  logic [STAT_W-1:0]   status;
  logic [STAT_W-1:0]   next_status;
  logic [STAT_W-1:0]   mask;
  logic [STAT_W-1:0]   next_mask;
  logic [WORD_W-1:0]   last_block;
  logic [WORD_W-1:0]   next_last_block;
  logic [31:0]         prdata;
  logic [31:0]         next_prdata;
  tbtc_ev_e            pend_kind;
  tbtc_ev_e            next_pend_kind;
  logic [WORD_W-1:0]   pend_data;
  logic [WORD_W-1:0]   next_pend_data;
  tbtc_ev_e            cur_kind;
  tbtc_ev_e            next_cur_kind;
  logic [WORD_W-1:0]   cur_data;
  logic [WORD_W-1:0]   next_cur_data;
  tbtc_state_e         state;
  tbtc_state_e         next_state;
  logic                overflow;
  logic                next_overflow;
  logic [WORD_W-1:0]   mem_addr;
  logic [WORD_W-1:0]   next_mem_addr;
  logic [WORD_W-1:0]   mem_wdata;
  logic [WORD_W-1:0]   next_mem_wdata;
  logic                mem_we;
  logic                next_mem_we;
  logic [WORD_W-1:0]   wword;
  logic [WORD_W-1:0]   next_wword;
  logic                wword_stb;
  logic                next_wword_stb;

  logic [WORD_W-1:0]   rword_swapped;
  logic [WORD_W-1:0]   mem_swapped;
  logic                setup;
  logic                access;
  logic                mapped;
  logic                mem_done;
  tbtc_ev_e            ev_kind;
  logic [WORD_W-1:0]   ev_data;
  logic [STAT_W-1:0]   set_bits;

  tbtc_group_swap u_swap_read (
    .word_in  (TAPE_RWORD),
    .reverse  (reverse),
    .word_out (rword_swapped)
  );

  tbtc_group_swap u_swap_write (
    .word_in  (MEM_RDATA),
    .reverse  (reverse),
    .word_out (mem_swapped)
  );

  // ---------------------------------------------------------------
  // Bus and port glue
  // ---------------------------------------------------------------
  assign setup    = PSEL && !PENABLE;
  assign access   = PSEL && PENABLE;
  assign mapped   = (PADDR == REG_CTRL) || (PADDR == REG_STATUS) ||
                    (PADDR == REG_MASK) || (PADDR == REG_BLOCK);
  assign PREADY   = 1'b1;
  assign PSLVERR  = access && !mapped;
  assign PRDATA   = prdata;
  assign IRQ      = |(status & mask);
  assign MEM_REQ  = (state != ST_IDLE);
  assign MEM_WE   = mem_we;
  assign MEM_ADDR = mem_addr;
  assign MEM_WDATA = mem_wdata;
  assign mem_done = MEM_REQ && MEM_ACK;
  assign TAPE_WWORD_STB = wword_stb;
  assign TAPE_WWORD = wword;
  assign TAPE_RUN = active;
  assign TAPE_REVERSE = reverse;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    next_active = active;
    next_fn = fn;
    next_continuous_mode = continuous_mode;
    next_reverse = reverse;
    next_halted = halted;
    next_mask = mask;
    next_last_block = last_block;
    next_prdata = prdata;
    next_pend_kind = pend_kind;
    next_pend_data = pend_data;
    next_cur_kind = cur_kind;
    next_cur_data = cur_data;
    next_state = state;
    next_overflow = overflow;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_mem_we = mem_we;
    next_wword = wword;
    next_wword_stb = 1'b0;
    set_bits = '0;
    ev_kind = EV_NONE;
    ev_data = '0;

    // Tape events are taken only while running and not stopped by overflow.
    if (active && !halted)
    begin
      if (fn == FN_SEARCH && TAPE_MARK_STB)
      begin
        ev_kind = EV_MARK;
        ev_data = TAPE_MARK_NUM;
      end
      else if (fn == FN_READ && TAPE_RWORD_STB)
      begin
        ev_kind = EV_RWORD;
        ev_data = rword_swapped;
      end
      else if (fn == FN_WRITE && TAPE_WREQ_STB)
        ev_kind = EV_WREQ;
    end

    // Block end closes a single-block data transfer.
    if (active && TAPE_BLOCK_END && !continuous_mode &&
        (fn == FN_READ || fn == FN_WRITE))
      set_bits[STAT_DONE] = 1'b1;

    unique case (state)
      ST_IDLE:
      begin
        if (pend_kind != EV_NONE)
        begin
          next_cur_kind = pend_kind;
          next_cur_data = pend_data;
          next_pend_kind = EV_NONE;
          next_mem_addr = CNT_LOC;
          next_mem_we = 1'b0;
          next_state = ST_RD_CNT;
        end
      end
      ST_RD_CNT:
      begin
        if (mem_done)
        begin
          next_mem_wdata = inc_word(MEM_RDATA);
          next_overflow = (inc_word(MEM_RDATA) == '0);
          next_mem_we = 1'b1;
          next_state = ST_WR_CNT;
        end
      end
      ST_WR_CNT:
      begin
        if (mem_done)
        begin
          next_mem_addr = PTR_LOC;
          next_mem_we = 1'b0;
          next_state = ST_RD_PTR;
        end
      end
      ST_RD_PTR:
      begin
        if (mem_done)
        begin
          if (cur_kind == EV_MARK)
          begin
            // The pointer is left as it is; the number lands where it points.
            next_mem_addr = MEM_RDATA;
            next_mem_wdata = cur_data;
            next_mem_we = 1'b1;
            next_state = ST_XFER;
          end
          else
          begin
            next_mem_wdata = inc_word(MEM_RDATA);
            next_mem_we = 1'b1;
            next_state = ST_WR_PTR;
          end
        end
      end
      ST_WR_PTR:
      begin
        if (mem_done)
        begin
          next_mem_addr = mem_wdata;
          next_mem_wdata = cur_data;
          next_mem_we = (cur_kind == EV_RWORD);
          next_state = ST_XFER;
        end
      end
      ST_XFER:
      begin
        if (mem_done)
        begin
          if (cur_kind == EV_WREQ)
          begin
            next_wword = mem_swapped;
            next_wword_stb = 1'b1;
          end
          if (cur_kind == EV_MARK)
          begin
            next_last_block = cur_data;
            set_bits[STAT_BLOCK] = 1'b1;
            if (!continuous_mode)
              set_bits[STAT_DONE] = 1'b1;
          end
          if (overflow && (continuous_mode || cur_kind != EV_MARK))
          begin
            next_halted = 1'b1;
            next_pend_kind = EV_NONE;
            if (continuous_mode)
              set_bits[STAT_DONE] = 1'b1;
          end
          next_mem_we = 1'b0;
          next_state = ST_IDLE;
        end
      end
    endcase

    // A new event while one still waits is lost and reported.
    if (ev_kind != EV_NONE)
    begin
      if (next_pend_kind != EV_NONE)
        set_bits[STAT_OVERRUN] = 1'b1;
      else if (!next_halted)
      begin
        next_pend_kind = ev_kind;
        next_pend_data = ev_data;
      end
    end

    // Register bus: read data is captured in the setup cycle.
    if (setup && !PWRITE)
    begin
      next_prdata = '0;
      unique case (PADDR)
        REG_CTRL:   next_prdata[5:0] = {1'b0, reverse, continuous_mode, fn, active};
        REG_STATUS: next_prdata[STAT_W-1:0] = status;
        REG_MASK:   next_prdata[STAT_W-1:0] = mask;
        REG_BLOCK:  next_prdata[WORD_W-1:0] = last_block;
        default:    next_prdata = '0;
      endcase
    end

    // Only bits that were reported are cleared, so a new event survives.
    next_status = status;
    if (access && !PWRITE && PADDR == REG_STATUS)
      next_status = status & ~prdata[STAT_W-1:0];
    next_status = next_status | set_bits;

    if (access && PWRITE)
    begin
      if (PADDR == REG_MASK)
        next_mask = PWDATA[STAT_W-1:0];
      else if (PADDR == REG_CTRL)
      begin
        if (PWDATA[CTRL_TURN])
          next_reverse = !reverse;
        else
        begin
          next_fn = tbtc_fn_e'(PWDATA[CTRL_FN_HI:CTRL_FN_LO]);
          next_continuous_mode = PWDATA[CTRL_CONT];
          next_reverse = PWDATA[CTRL_REV];
          next_active = PWDATA[CTRL_GO];
          if (PWDATA[CTRL_GO] && !active)
            next_halted = 1'b0;
          if (!PWDATA[CTRL_GO])
            next_pend_kind = EV_NONE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      active <= 1'b0;
      fn <= FN_MOVE;
      continuous_mode <= 1'b0;
      reverse <= 1'b0;
      halted <= 1'b0;
      status <= STATUS_RST;
      mask <= MASK_RST;
      last_block <= '0;
      prdata <= '0;
      pend_kind <= EV_NONE;
      pend_data <= '0;
      cur_kind <= EV_NONE;
      cur_data <= '0;
      state <= ST_IDLE;
      overflow <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
      mem_we <= 1'b0;
      wword <= '0;
      wword_stb <= 1'b0;
    end
    else
    begin
      active <= next_active;
      fn <= next_fn;
      continuous_mode <= next_continuous_mode;
      reverse <= next_reverse;
      halted <= next_halted;
      status <= next_status;
      mask <= next_mask;
      last_block <= next_last_block;
      prdata <= next_prdata;
      pend_kind <= next_pend_kind;
      pend_data <= next_pend_data;
      cur_kind <= next_cur_kind;
      cur_data <= next_cur_data;
      state <= next_state;
      overflow <= next_overflow;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      mem_we <= next_mem_we;
      wword <= next_wword;
      wword_stb <= next_wword_stb;
    end
  end

endmodule : tbtc_top

// *** hdl/tbtc_pkg.sv ***
// Package of constants and types for the tape block transfer control.
package tbtc_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 12;
  localparam int unsigned PADDR_W = 8;
  localparam int unsigned STAT_W = 3;

  // ---------------------------------------------------------------
  // APB register byte offsets
  // ---------------------------------------------------------------
  localparam logic [PADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [PADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [PADDR_W-1:0] REG_MASK   = 8'h08;
  localparam logic [PADDR_W-1:0] REG_BLOCK  = 8'h0C;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_GO    = 0;
  localparam int unsigned CTRL_FN_LO = 1;
  localparam int unsigned CTRL_FN_HI = 2;
  localparam int unsigned CTRL_CONT  = 3;
  localparam int unsigned CTRL_REV   = 4;
  localparam int unsigned CTRL_TURN  = 5;

  // ---------------------------------------------------------------
  // Status and mask fields, reset values
  // ---------------------------------------------------------------
  localparam int unsigned STAT_DONE    = 0;
  localparam int unsigned STAT_BLOCK   = 1;
  localparam int unsigned STAT_OVERRUN = 2;
  localparam logic [STAT_W-1:0] STATUS_RST = 3'h0;
  localparam logic [STAT_W-1:0] MASK_RST   = 3'h0;

  // ---------------------------------------------------------------
  // Fixed memory locations of the break words
  // ---------------------------------------------------------------
  localparam logic [WORD_W-1:0] CNT_LOC = 12'hFEC;
  localparam logic [WORD_W-1:0] PTR_LOC = 12'hFED;
  localparam logic [WORD_W-1:0] WORD_ONE = 12'h001;

  // ---------------------------------------------------------------
  // Functions, pending event kinds and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {FN_MOVE, FN_SEARCH, FN_READ, FN_WRITE} tbtc_fn_e;
  typedef enum logic [1:0] {EV_NONE, EV_MARK, EV_RWORD, EV_WREQ} tbtc_ev_e;
  typedef enum logic [2:0] {ST_IDLE, ST_RD_CNT, ST_WR_CNT, ST_RD_PTR, ST_WR_PTR,
                            ST_XFER} tbtc_state_e;

endpackage : tbtc_pkg

// *** hdl/tbtc_group_swap.sv ***
// Reorders the four three-bit groups of a word for opposite-direction transfers.
`timescale 1ns/1ps
module tbtc_group_swap
  import tbtc_pkg::*;
(
  input  wire logic [WORD_W-1:0] word_in,
  input  wire logic              reverse,
  output logic      [WORD_W-1:0] word_out
);

  // Bits 0-2 land at 9-11 and bits 3-5 at 6-8; the swap is its own inverse.
  always_comb
  begin
    if (reverse)
      word_out = {word_in[2:0], word_in[5:3], word_in[8:6], word_in[11:9]};
    else
      word_out = word_in;
  end

endmodule : tbtc_group_swap

// *** sim/tbtc_properties.sv ***
// Concurrent checks on the ports of the tape block transfer controller.
`timescale 1ns/1ps
module tbtc_properties
  import tbtc_pkg::*;
(
  input wire logic              CORE_CLK,
  input wire logic              RSTN,
  input wire logic              MEM_REQ,
  input wire logic              MEM_WE,
  input wire logic [WORD_W-1:0] MEM_ADDR,
  input wire logic [WORD_W-1:0] MEM_WDATA,
  input wire logic              MEM_ACK,
  input wire logic [WORD_W-1:0] MEM_RDATA,
  input wire logic              TAPE_WWORD_STB,
  input wire logic [WORD_W-1:0] TAPE_WWORD,
  input wire logic              TAPE_RUN,
  input wire logic              TAPE_REVERSE
);
  logic done_acc;
  logic ptr_rd_seen;

  assign done_acc = MEM_REQ && MEM_ACK;

  // A pointer write only steers data when it directly follows the pointer read.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
      ptr_rd_seen <= 1'b0;
    else if (done_acc)
      ptr_rd_seen <= !MEM_WE && MEM_ADDR == PTR_LOC;
  end

  function automatic logic [WORD_W-1:0] swapped(input logic [WORD_W-1:0] w);
    return {w[2:0], w[5:3], w[8:6], w[11:9]};
  endfunction : swapped

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  // ---------------------------------------------------------------
  // Break sequence
  // ---------------------------------------------------------------
  a_break_opens_count:
    assert property ($rose(MEM_REQ) |-> !MEM_WE && MEM_ADDR == CNT_LOC)
    else $error("Break did not open with a counter read.");
  a_break_bounded:
    assert property ($rose(MEM_REQ) |-> ##[1:60] !MEM_REQ)
    else $error("Break did not end in time.");
  a_count_steps_up:
    assert property (done_acc && !MEM_WE && MEM_ADDR == CNT_LOC |=> MEM_REQ && MEM_WE
      && MEM_ADDR == CNT_LOC && MEM_WDATA == $past(MEM_RDATA) + WORD_ONE)
    else $error("Counter write-back wrong.");
  a_pointer_after_read:
    assert property (done_acc && !MEM_WE && MEM_ADDR == PTR_LOC |=> MEM_WE && (MEM_ADDR == PTR_LOC
      ? MEM_WDATA == $past(MEM_RDATA) + WORD_ONE : MEM_ADDR == $past(MEM_RDATA)))
    else $error("Pointer use after its read is wrong.");
  a_data_at_pointer:
    assert property (done_acc && MEM_WE && MEM_ADDR == PTR_LOC && ptr_rd_seen |=> MEM_REQ
      && MEM_ADDR == $past(MEM_WDATA))
    else $error("Data access not at the new pointer.");
  a_write_word_order:
    assert property (done_acc && !MEM_WE && MEM_ADDR != CNT_LOC && MEM_ADDR != PTR_LOC
      |=> TAPE_WWORD_STB && TAPE_WWORD == (TAPE_REVERSE ? swapped($past(MEM_RDATA))
      : $past(MEM_RDATA)))
    else $error("Tape word wrong after data read.");
  a_turn_keeps_run:
    assert property ($changed(TAPE_REVERSE) && $past(TAPE_RUN) |-> TAPE_RUN)
    else $error("Direction change stopped the tape.");
  a_request_held:
    assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE)
      && $stable(MEM_WDATA))
    else $error("Memory request changed before its answer.");
endmodule : tbtc_properties

bind tbtc_top tbtc_properties u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .MEM_REQ(MEM_REQ),
  .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
  .MEM_RDATA(MEM_RDATA), .TAPE_WWORD_STB(TAPE_WWORD_STB), .TAPE_WWORD(TAPE_WWORD),
  .TAPE_RUN(TAPE_RUN), .TAPE_REVERSE(TAPE_REVERSE));

// *** sim/tbtc_mem_model.sv ***
// Behavioural host memory answering the controller's break accesses.
`timescale 1ns/1ps
module tbtc_mem_model
  import tbtc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              req,
  input  wire logic              we,
  input  wire logic [WORD_W-1:0] addr,
  input  wire logic [WORD_W-1:0] wdata,
  input  wire logic [3:0]        lat,
  output logic                   ack,
  output logic      [WORD_W-1:0] rdata
);
  logic [WORD_W-1:0] mem [0:4095];
  logic [3:0]        cnt;

  // Read lines toggle between answers so that a stale sample never looks valid.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      ack   <= 1'b0;
      cnt   <= 4'h0;
      rdata <= 12'h000;
    end
    else if (req && ack)
    begin
      if (we)
        mem[addr] <= wdata;
      ack   <= 1'b0;
      cnt   <= 4'h0;
      rdata <= ~rdata;
    end
    else if (req && cnt >= lat)
    begin
      ack   <= 1'b1;
      rdata <= mem[addr];
    end
    else
    begin
      cnt   <= req ? cnt + 4'h1 : 4'h0;
      rdata <= ~rdata;
    end
  end
endmodule : tbtc_mem_model

// *** sim/tbtc_tb_top.sv ***
// Self-checking bench for the tape block transfer controller.
`timescale 1ns/1ps
module tbtc_tb_top
  import tbtc_pkg::*;
;
  logic               clk, rstn, psel, penable, pwrite, mk, rw, wq, be;
  logic               irq, req, we, ack, wstb, run, rev, rdy, err, serr;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata, rdat;
  logic [WORD_W-1:0]  num, maddr, mwd, mrd, ww;
  logic [3:0]         lat;
  int                 bad_count, n_compared, cyc, i;

  tbtc_top u_dut (
    .CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(rdy), .PSLVERR(err), .IRQ(irq),
    .MEM_REQ(req), .MEM_WE(we), .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_ACK(ack),
    .MEM_RDATA(mrd), .TAPE_MARK_STB(mk), .TAPE_MARK_NUM(num), .TAPE_RWORD_STB(rw),
    .TAPE_RWORD(num), .TAPE_WREQ_STB(wq), .TAPE_BLOCK_END(be), .TAPE_WWORD_STB(wstb),
    .TAPE_WWORD(ww), .TAPE_RUN(run), .TAPE_REVERSE(rev));
  tbtc_mem_model u_mem (.clk(clk), .rstn(rstn), .req(req), .we(we), .addr(maddr),
    .wdata(mwd), .lat(lat), .ack(ack), .rdata(mrd));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  function automatic logic [11:0] sw(input logic [11:0] w);
    return {w[2:0], w[5:3], w[8:6], w[11:9]};
  endfunction : sw

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // The apb and ev tasks start at a rising edge and return at a falling one, where outputs are settled.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (rdy !== 1'b1);
    rdat = prdata;
    serr = err;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask : apb

  task automatic ev(input int k, input logic [11:0] v);
    int j;
    @(posedge clk);
    num <= v;
    case (k)
      0: mk <= 1'b1;
      1: rw <= 1'b1;
      2: wq <= 1'b1;
      default: be <= 1'b1;
    endcase
    @(posedge clk);
    {mk, rw, wq, be} <= 4'h0;
    for (j = 0; j < 60 && (j < 8 || req); j++)
      @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : ev

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk({irq, req, run, rev, wstb, rdy}, 32'h01);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rdat, {29'h0, STATUS_RST});
    apb(1'b0, REG_MASK, 32'h0);
    chk(rdat, {29'h0, MASK_RST});
    apb(1'b0, 8'h10, 32'h0);
    chk(serr, 1'b1);
    chk(rdat, 32'h0);
  endtask : t_reset

  task automatic t_search;
    u_mem.mem[CNT_LOC] = 12'h000;
    u_mem.mem[PTR_LOC] = 12'h200;
    apb(1'b1, REG_MASK, 32'h1);
    apb(1'b1, REG_CTRL, 32'h03);
    for (i = 0; i < 2; i++)
    begin
      ev(0, 12'h00E + 12'(i));
      chk(irq, 1'b1);
      apb(1'b0, REG_STATUS, 32'h0);
    end
    chk(irq, 1'b0);
    apb(1'b1, REG_CTRL, 32'h20);
    chk({run, rev}, 2'h3);
    ev(0, 12'h010);
    chk(u_mem.mem[12'h200], 12'h010);
    u_mem.mem[CNT_LOC] = 12'hFFD;
    apb(1'b1, REG_CTRL, 32'h1B);
    apb(1'b0, REG_STATUS, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      ev(0, 12'h00F - 12'(i));
      chk(irq, i == 2);
    end
    chk(u_mem.mem[12'h200], 12'h00D);
    chk(u_mem.mem[PTR_LOC], 12'h200);
    apb(1'b0, REG_BLOCK, 32'h0);
    chk(rdat, 32'h00D);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rdat[STAT_DONE], 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, REG_CTRL, 32'h10);
  endtask : t_search

  // The first word overwrites the counter and the second the pointer, with a slow memory.
  task automatic t_boot;
    lat = 4'h3;
    u_mem.mem[CNT_LOC] = 12'hFFE;
    u_mem.mem[PTR_LOC] = 12'hFEB;
    u_mem.mem[12'h302] = 12'h000;
    apb(1'b1, REG_CTRL, 32'h0D);
    ev(1, 12'hFFD);
    ev(1, 12'h2FF);
    ev(1, 12'hABC);
    ev(1, 12'h123);
    ev(1, 12'h456);
    chk(u_mem.mem[12'h300], 12'hABC);
    chk(u_mem.mem[12'h301], 12'h123);
    chk(u_mem.mem[12'h302], 12'h000);
    chk(u_mem.mem[CNT_LOC], 12'h000);
    chk(u_mem.mem[PTR_LOC], 12'h301);
    apb(1'b1, REG_CTRL, 32'h00);
    lat = 4'h0;
  endtask : t_boot

  task automatic t_rev;
    u_mem.mem[CNT_LOC] = 12'hFFE;
    u_mem.mem[PTR_LOC] = 12'h3FF;
    u_mem.mem[12'h402] = 12'h000;
    apb(1'b1, REG_CTRL, 32'h15);
    ev(1, 12'h123);
    ev(1, 12'hA5C);
    ev(1, 12'h777);
    chk(u_mem.mem[12'h400], sw(12'h123));
    chk(u_mem.mem[12'h401], sw(12'hA5C));
    chk(u_mem.mem[12'h402], 12'h000);
    apb(1'b1, REG_CTRL, 32'h10);
    apb(1'b0, REG_STATUS, 32'h0);
    u_mem.mem[CNT_LOC] = 12'hFF0;
    u_mem.mem[PTR_LOC] = 12'h4FF;
    u_mem.mem[12'h500] = 12'h123;
    apb(1'b1, REG_CTRL, 32'h17);
    ev(2, 12'h000);
    chk(ww, sw(12'h123));
    chk(u_mem.mem[PTR_LOC], 12'h500);
    ev(3, 12'h000);
    chk(irq, 1'b1);
    apb(1'b1, REG_CTRL, 32'h10);
  endtask : t_rev

  // Three word strobes in a row: the third finds the waiting slot full and is lost.
  task automatic t_overrun;
    u_mem.mem[CNT_LOC] = 12'h000;
    u_mem.mem[PTR_LOC] = 12'h5FF;
    u_mem.mem[12'h602] = 12'h000;
    apb(1'b0, REG_STATUS, 32'h0);
    apb(1'b1, REG_CTRL, 32'h05);
    @(posedge clk);
    num <= 12'h111;
    rw  <= 1'b1;
    repeat (3) @(posedge clk);
    rw  <= 1'b0;
    repeat (40) @(negedge clk);
    chk(u_mem.mem[12'h600], 12'h111);
    chk(u_mem.mem[12'h601], 12'h111);
    chk(u_mem.mem[12'h602], 12'h000);
    chk(u_mem.mem[PTR_LOC], 12'h601);
    chk(irq, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rdat, 32'h1 << STAT_OVERRUN);
    apb(1'b1, REG_CTRL, 32'h00);
  endtask : t_overrun

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    {rstn, psel, penable, pwrite, mk, rw, wq, be} = 8'h00;
    paddr  = 8'h00;
    pwdata = 32'h0;
    num    = 12'h000;
    lat    = 4'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    t_reset();
    t_search();
    t_boot();
    t_rev();
    t_overrun();
    tally_and_finish();
  end
endmodule : tbtc_tb_top
